// File: gpio_sync_error_pin_control.sv
/*
  Pin configuration register with external mux drive, sync input
  handling (plain reset or gated start) and error pin modes.
  Assumes one 125 MHz clock, a simple strobe register port, and a
  channel sequencer on the same clock that pulses i_chan_switch.
*/
// Implementation choice: the strobed register port.
module gpio_sync_error_pin_control
  import gpio_sync_error_pin_control_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst_n,
  // Register port
  input  wire logic [ADDR_W-1:0]    i_addr,
  input  wire logic [31:0]          i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [31:0]          o_rdata,
  // Channel sequencer and mode inputs
  input  wire logic                 i_chan_switch,
  input  wire logic [3:0]           i_chan_index,
  input  wire logic                 i_multi_chan,
  input  wire logic                 i_gated_sync_select,
  input  wire logic                 i_status_err,
  // Pins
  input  wire logic                 i_sync_pin_n,
  input  wire logic                 i_fault_pin,
  output logic                      o_fault_pin_out,
  output logic                      o_fault_pin_oe,
  output logic      [3:0]           o_mux_sel,
  output logic                      o_mux_oe,
  output logic                      o_upper_outputs_enable,
  // Converter control
  output logic                      o_conv_reset,
  output logic                      o_conv_start,
  output logic                      o_conv_withheld,
  output logic                      o_ext_err,
  // Interrupt
  output logic                      o_irq
);

  // Decode shared by read and write paths
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction : hit

  // Configuration state
  logic                upper_en_r,   upper_en_nxt;
  logic                mux_drive_r,  mux_drive_nxt;
  logic                sync_en_r,    sync_en_nxt;
  logic [1:0]          fault_mode_r, fault_mode_nxt;
  logic                fault_lvl_r,  fault_lvl_nxt;
  logic [SETTLE_W-1:0] settle_r,     settle_nxt;
  logic [IRQ_W-1:0]    irq_en_r,     irq_en_nxt;
  logic [IRQ_W-1:0]    irq_stat_r,   irq_stat_nxt;
  logic [31:0]         rdata_r,      rdata_nxt;
  logic                irq_r,        irq_nxt;

  // Pin synchronisers
  logic                sync_ff1_r, sync_ff2_r, sync_ff3_r, sync_lvl_r, sync_lvl_nxt;
  logic                flt_ff1_r,  flt_ff2_r,  flt_ff3_r,  flt_lvl_r,  flt_lvl_nxt;

  // Sequencer state
  seq_state_t          state_r,      state_nxt;
  logic [SETTLE_W-1:0] cnt_r,        cnt_nxt;
  logic [3:0]          mux_sel_r,    mux_sel_nxt;
  logic [4:0]          chan_cnt_r,   chan_cnt_nxt;
  logic                start_r,      start_nxt;
  logic                creset_r,     creset_nxt;
  logic                fpin_out_r,   fpin_out_nxt;
  logic                fpin_oe_r,    fpin_oe_nxt;
  logic                ext_err_r,    ext_err_nxt;
  logic                gated_mode;
  logic                sync_rise;
  logic [IRQ_W-1:0]    events;

  assign gated_mode = sync_en_r & i_gated_sync_select & i_multi_chan;
  assign sync_rise  = sync_lvl_nxt & ~sync_lvl_r;

  // Pin filters: a level counts once the second and third stages agree
  always_comb begin
    sync_lvl_nxt = (sync_ff2_r == sync_ff3_r) ? sync_ff3_r : sync_lvl_r;
    flt_lvl_nxt  = (flt_ff2_r == flt_ff3_r) ? flt_ff3_r : flt_lvl_r;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      {sync_ff1_r, sync_ff2_r, sync_ff3_r, sync_lvl_r} <= 4'hf;
      {flt_ff1_r, flt_ff2_r, flt_ff3_r, flt_lvl_r}     <= 4'hf;
    end else begin
      sync_ff1_r <= i_sync_pin_n;
      sync_ff2_r <= sync_ff1_r;
      sync_ff3_r <= sync_ff2_r;
      sync_lvl_r <= sync_lvl_nxt;
      flt_ff1_r  <= i_fault_pin;
      flt_ff2_r  <= flt_ff1_r;
      flt_ff3_r  <= flt_ff2_r;
      flt_lvl_r  <= flt_lvl_nxt;
    end
  end

  // Register writes, reads and interrupt status
  always_comb begin
    upper_en_nxt   = upper_en_r;
    mux_drive_nxt  = mux_drive_r;
    sync_en_nxt    = sync_en_r;
    fault_mode_nxt = fault_mode_r;
    fault_lvl_nxt  = fault_lvl_r;
    settle_nxt     = settle_r;
    irq_en_nxt     = irq_en_r;
    irq_stat_nxt   = irq_stat_r;
    rdata_nxt      = 32'h0000_0000;
    if (i_wr && hit(i_addr, IDX_PIN_CFG)) begin
      upper_en_nxt   = i_wdata[BIT_UPPER_EN];
      mux_drive_nxt  = i_wdata[BIT_MUX_DRIVE];
      sync_en_nxt    = i_wdata[BIT_SYNC_EN];
      fault_mode_nxt = i_wdata[FAULT_MODE_HI:FAULT_MODE_LO];
      fault_lvl_nxt  = i_wdata[BIT_FAULT_LVL];
    end
    if (i_wr && hit(i_addr, IDX_SETTLE)) settle_nxt = i_wdata[SETTLE_W-1:0];
    if (i_wr && hit(i_addr, IDX_IRQ_EN)) irq_en_nxt = i_wdata[IRQ_W-1:0];
    if (i_wr && hit(i_addr, IDX_IRQ_CLR)) irq_stat_nxt = irq_stat_r & ~i_wdata[IRQ_W-1:0];
    // Set after clear so a same-cycle event is never lost
    irq_stat_nxt = irq_stat_nxt | events;
    if (i_rd) begin
      if (hit(i_addr, IDX_PIN_CFG)) begin
        // Reserved top bits and unmodelled low byte read zero
        rdata_nxt[CFG_W-1:CFG_W-2]              = 2'h0;
        rdata_nxt[BIT_UPPER_EN]                 = upper_en_r;
        rdata_nxt[BIT_MUX_DRIVE]                = mux_drive_r;
        rdata_nxt[BIT_SYNC_EN]                  = sync_en_r;
        rdata_nxt[FAULT_MODE_HI:FAULT_MODE_LO]  = fault_mode_r;
        rdata_nxt[BIT_FAULT_LVL] = (fault_mode_r == FAULT_INPUT) ? flt_lvl_r
                                                                 : fault_lvl_r;
      end else if (hit(i_addr, IDX_IRQ_STAT)) begin
        rdata_nxt[IRQ_W-1:0] = irq_stat_r;
      end else if (hit(i_addr, IDX_IRQ_EN)) begin
        rdata_nxt[IRQ_W-1:0] = irq_en_r;
      end else if (hit(i_addr, IDX_SETTLE)) begin
        rdata_nxt[SETTLE_W-1:0] = settle_r;
      end
    end
    irq_nxt = |(irq_stat_r & irq_en_r);
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      upper_en_r   <= PIN_CFG_RESET[BIT_UPPER_EN];
      mux_drive_r  <= PIN_CFG_RESET[BIT_MUX_DRIVE];
      sync_en_r    <= PIN_CFG_RESET[BIT_SYNC_EN];
      fault_mode_r <= PIN_CFG_RESET[FAULT_MODE_HI:FAULT_MODE_LO];
      fault_lvl_r  <= PIN_CFG_RESET[BIT_FAULT_LVL];
      settle_r     <= SETTLE_RESET;
      irq_en_r     <= '0;
      irq_stat_r   <= '0;
      rdata_r      <= 32'h0000_0000;
      irq_r        <= 1'b0;
    end else begin
      upper_en_r   <= upper_en_nxt;
      mux_drive_r  <= mux_drive_nxt;
      sync_en_r    <= sync_en_nxt;
      fault_mode_r <= fault_mode_nxt;
      fault_lvl_r  <= fault_lvl_nxt;
      settle_r     <= settle_nxt;
      irq_en_r     <= irq_en_nxt;
      irq_stat_r   <= irq_stat_nxt;
      rdata_r      <= rdata_nxt;
      irq_r        <= irq_nxt;
    end
  end

  // Channel sequencing, settling and sync gating
  always_comb begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    mux_sel_nxt  = mux_sel_r;
    chan_cnt_nxt = chan_cnt_r;
    start_nxt    = 1'b0;
    events       = '0;
    // Plain sync mode: low level holds modulator and filter in reset
    creset_nxt   = sync_en_r & ~gated_mode & ~sync_lvl_nxt;
    unique case (state_r)
      S_IDLE:   ;
      S_SETTLE: begin
        if (cnt_r == '0) begin
          start_nxt = 1'b1;
          state_nxt = S_IDLE;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      S_HOLD: begin
        // Rising sync, or leaving gated mode, lets the channel go on
        if (sync_rise || !gated_mode) begin
          state_nxt = S_SETTLE;
          events[IRQ_RELEASED] = 1'b1;
        end
      end
    endcase
    if (i_chan_switch) begin
      // Only the select pins move; input pair choice stays per channel
      mux_sel_nxt = i_chan_index;
      cnt_nxt     = settle_r;
      if (gated_mode && !sync_lvl_nxt) begin
        state_nxt = S_HOLD;
        events[IRQ_WITHHELD] = 1'b1;
      end else begin
        state_nxt = S_SETTLE;
      end
      if (mux_drive_r) begin
        // Host must move to the next input pair after a full span
        if (chan_cnt_r == MUX_SPAN - 5'h01) begin
          chan_cnt_nxt = 5'h00;
          events[IRQ_MUX_WRAP] = 1'b1;
        end else begin
          chan_cnt_nxt = chan_cnt_r + 5'h01;
        end
      end
    end
    events[IRQ_FAULT_IN] = (fault_mode_r == FAULT_INPUT) & ~flt_lvl_nxt & flt_lvl_r;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_r    <= S_IDLE;
      cnt_r      <= '0;
      mux_sel_r  <= 4'h0;
      chan_cnt_r <= 5'h00;
      start_r    <= 1'b0;
      creset_r   <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      mux_sel_r  <= mux_sel_nxt;
      chan_cnt_r <= chan_cnt_nxt;
      start_r    <= start_nxt;
      creset_r   <= creset_nxt;
    end
  end

  // Error pin drive per mode
  always_comb begin
    fpin_out_nxt = 1'b1;
    fpin_oe_nxt  = 1'b0;
    ext_err_nxt  = 1'b0;
    unique case (fault_mode_nxt)
      FAULT_OFF:   ;
      FAULT_INPUT: ext_err_nxt = ~flt_lvl_nxt;
      FAULT_DRAIN: begin
        // Open drain: pull low only on error, wired-OR across parts
        fpin_out_nxt = 1'b0;
        fpin_oe_nxt  = i_status_err;
      end
      FAULT_GPO: begin
        fpin_out_nxt = fault_lvl_nxt;
        fpin_oe_nxt  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      fpin_out_r <= 1'b1;
      fpin_oe_r  <= 1'b0;
      ext_err_r  <= 1'b0;
    end else begin
      fpin_out_r <= fpin_out_nxt;
      fpin_oe_r  <= fpin_oe_nxt;
      ext_err_r  <= ext_err_nxt;
    end
  end

  // Outputs, all from flops but o_conv_withheld, decoded from state_r
  assign o_rdata                = rdata_r;
  assign o_irq                  = irq_r;
  assign o_mux_sel              = mux_sel_r;
  assign o_mux_oe               = mux_drive_r;
  assign o_upper_outputs_enable = upper_en_r;
  assign o_conv_reset           = creset_r;
  assign o_conv_start           = start_r;
  assign o_conv_withheld        = (state_r == S_HOLD);
  assign o_fault_pin_out        = fpin_out_r;
  assign o_fault_pin_oe         = fpin_oe_r;
  assign o_ext_err              = ext_err_r;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  a_cfg_readback: assert property (
    i_wr && hit(i_addr, IDX_PIN_CFG) ##1 !i_wr ##1 i_rd && hit(i_addr, IDX_PIN_CFG)
    |=> o_rdata[15:9] == ($past(i_wdata[15:9], 3) & 7'h1f))
    else $error("pin configuration readback mismatch");
  a_upper_enable: assert property (
    i_wr && hit(i_addr, IDX_PIN_CFG) |=> o_upper_outputs_enable == $past(i_wdata[BIT_UPPER_EN]))
    else $error("upper outputs enable not following bit 13");
  a_mux_follow: assert property (
    i_chan_switch |=> o_mux_sel == $past(i_chan_index))
    else $error("mux select not following sequencer");
  a_settle_wait: assert property (
    i_chan_switch && settle_r == 16'h0003 && !(gated_mode && !sync_lvl_nxt)
    ##1 !i_chan_switch [*4] |=> o_conv_start)
    else $error("conversion start not after settle delay");
  a_plain_reset: assert property (
    sync_en_r && !gated_mode && !sync_lvl_nxt |=> o_conv_reset)
    else $error("sync low did not hold converter in reset");
  a_gated_noreset: assert property (
    gated_mode |=> !o_conv_reset || !$past(gated_mode))
    else $error("gated sync mode reset the converter");
  a_gated_hold: assert property (
    i_chan_switch && gated_mode && !sync_lvl_nxt |=> o_conv_withheld)
    else $error("low sync at switch did not withhold");
  a_gated_release: assert property (
    o_conv_withheld && gated_mode && sync_rise |=> !o_conv_withheld)
    else $error("rising sync did not release withheld conversion");
  a_drain_low: assert property (
    fault_mode_r == FAULT_DRAIN && !(i_wr && hit(i_addr, IDX_PIN_CFG)) && i_status_err
    |=> o_fault_pin_oe && !o_fault_pin_out)
    else $error("open drain error output not pulling low");
  c_gated_cycle: cover property (o_conv_withheld ##[1:50] o_conv_start);
  c_mux_wrap:    cover property (events[IRQ_MUX_WRAP]);
  c_irq_raise:   cover property (!o_irq ##1 o_irq);
  c_plain_reset: cover property (o_conv_reset);

endmodule : gpio_sync_error_pin_control

// File: gpio_sync_error_pin_control_pkg.sv
/*
  Constants for the pin configuration block: register indices, byte
  addresses, field positions, reset values, error pin modes and
  interrupt bit positions.
  Assumes a 32-bit word bus where byte address = 4 x register index.
*/
package gpio_sync_error_pin_control_pkg;

  // Register indices and their byte addresses
  localparam logic [5:0] IDX_PIN_CFG   = 6'h06;
  localparam logic [5:0] IDX_IRQ_STAT  = 6'h10;
  localparam logic [5:0] IDX_IRQ_CLR   = 6'h11;
  localparam logic [5:0] IDX_IRQ_EN    = 6'h12;
  localparam logic [5:0] IDX_SETTLE    = 6'h13;
  localparam int         ADDR_W        = 8;

  // Pin configuration fields
  localparam int          CFG_W          = 16;
  localparam logic [15:0] PIN_CFG_RESET  = 16'h0800;
  localparam int          BIT_UPPER_EN   = 13;
  localparam int          BIT_MUX_DRIVE  = 12;
  localparam int          BIT_SYNC_EN    = 11;
  localparam int          FAULT_MODE_HI  = 10;
  localparam int          FAULT_MODE_LO  = 9;
  localparam int          BIT_FAULT_LVL  = 8;

  // Error pin modes
  localparam logic [1:0] FAULT_OFF      = 2'h0;
  localparam logic [1:0] FAULT_INPUT    = 2'h1;
  localparam logic [1:0] FAULT_DRAIN    = 2'h2;
  localparam logic [1:0] FAULT_GPO      = 2'h3;

  // External multiplexer sequence span
  localparam logic [4:0] MUX_SPAN       = 5'h10;

  // Interrupt bits
  localparam int         IRQ_W          = 4;
  localparam int         IRQ_WITHHELD   = 0;
  localparam int         IRQ_RELEASED   = 1;
  localparam int         IRQ_MUX_WRAP   = 2;
  localparam int         IRQ_FAULT_IN   = 3;

  // Settling delay register
  localparam int          SETTLE_W      = 16;
  localparam logic [15:0] SETTLE_RESET  = 16'h0000;

  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE   = 3'b001,
    S_SETTLE = 3'b010,
    S_HOLD   = 3'b100
  } seq_state_t;

endpackage : gpio_sync_error_pin_control_pkg

// File: pin_env_model.sv
/*
  Model of what sits outside the pins: the error pin wire with its
  pull-up, and the external mux that latches the select lines.
  Assumes the block's pin ports and a bench that may sink the error pin.
*/
module pin_env_model (
  // Block side
  input  wire logic       i_mclk,
  input  wire logic [3:0] i_mux_sel,
  input  wire logic       i_mux_oe,
  input  wire logic       i_fault_out,
  input  wire logic       i_fault_oe,
  // Bench side
  input  wire logic       i_pull_low,
  output logic            o_fault_wire,
  output logic      [3:0] o_mux_chan
);
  timeunit 1ns;
  timeprecision 1ps;

  // Shared wire: pull-up unless a driver sinks it
  assign o_fault_wire = ~i_pull_low & (~i_fault_oe | i_fault_out);

  // Mux sees floating selects when undriven, shown as a changing value
  always_ff @(posedge i_mclk) begin
    o_mux_chan <= i_mux_oe ? i_mux_sel : ~o_mux_chan;
  end
endmodule : pin_env_model

// File: gpio_sync_error_pin_control_tb_top.sv
/*
  Self-checking bench for the pin configuration block.
  Assumes the design package, the external pin model and a 125 MHz clock.
*/
module gpio_sync_error_pin_control_tb_top;
  import gpio_sync_error_pin_control_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // Stimulus
  logic        i_mclk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic        i_chan_switch = 1'b0, i_multi_chan = 1'b0, i_gated_sync_select = 1'b0;
  logic        i_status_err = 1'b0, i_sync_pin_n = 1'b1, pull_low = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0]  i_chan_index = 4'h0;
  // Observed
  logic [31:0] o_rdata, rv;
  logic [3:0]  o_mux_sel, mux_chan;
  logic        o_fault_pin_out, o_fault_pin_oe, o_mux_oe, o_upper_outputs_enable;
  logic        o_conv_reset, o_conv_start, o_conv_withheld, o_ext_err, o_irq, fault_wire;
  int          fails = 0, n_tests = 0, n;

  always #4 i_mclk = ~i_mclk;

  gpio_sync_error_pin_control gpio_sync_error_pin_control_i (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_chan_switch(i_chan_switch),
    .i_chan_index(i_chan_index), .i_multi_chan(i_multi_chan),
    .i_gated_sync_select(i_gated_sync_select), .i_status_err(i_status_err),
    .i_sync_pin_n(i_sync_pin_n), .i_fault_pin(fault_wire),
    .o_fault_pin_out(o_fault_pin_out), .o_fault_pin_oe(o_fault_pin_oe),
    .o_mux_sel(o_mux_sel), .o_mux_oe(o_mux_oe),
    .o_upper_outputs_enable(o_upper_outputs_enable), .o_conv_reset(o_conv_reset),
    .o_conv_start(o_conv_start), .o_conv_withheld(o_conv_withheld),
    .o_ext_err(o_ext_err), .o_irq(o_irq));

  pin_env_model pin_env_model_i (
    .i_mclk(i_mclk), .i_mux_sel(o_mux_sel), .i_mux_oe(o_mux_oe),
    .i_fault_out(o_fault_pin_out), .i_fault_oe(o_fault_pin_oe),
    .i_pull_low(pull_low), .o_fault_wire(fault_wire), .o_mux_chan(mux_chan));

  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Register port cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd

  task automatic cyc(input int k);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask : cyc

  // One sequencer switch, sampled at the edge where the task returns
  task automatic sw(input logic [3:0] idx);
    @(posedge i_mclk);
    i_chan_switch <= 1'b1;
    i_chan_index <= idx;
    @(posedge i_mclk);
    i_chan_switch <= 1'b0;
  endtask : sw

  // Bounded wait for the start pulse, cycles counted in n
  task automatic wait_start(input int lim);
    while (o_conv_start !== 1'b1 && n < lim) begin
      @(posedge i_mclk);
      #1 n++;
    end
  endtask : wait_start

  task automatic t_reset();
    rd(8'h18, rv);
    chk("cfg reset", rv, 32'h0000_0800);
    chk("upper en", o_upper_outputs_enable, 32'h0);
    chk("fault oe", o_fault_pin_oe, 32'h0);
  endtask : t_reset

  task automatic t_cfg();
    wr(8'h18, 32'h0000_ffff);
    rd(8'h18, rv);
    chk("cfg all ones", rv, 32'h0000_3f00);
    cyc(2);
    chk("upper en", o_upper_outputs_enable, 32'h1);
    chk("mux oe", o_mux_oe, 32'h1);
    chk("fault wire gpo", {o_fault_pin_oe, fault_wire}, 32'h3);
    wr(8'h18, 32'h0000_3e00);
    cyc(2);
    chk("fault out gpo", o_fault_pin_out, 32'h0);
    rd(8'h1c, rv);
    chk("unmapped", rv, 32'h0);
  endtask : t_cfg

  // Settle delay, mux select and the 16-channel wrap
  task automatic t_seq();
    wr(8'h4c, 32'h3);
    sw(4'h5);
    cyc(1);
    n = 2; // Counts the edge at which a pulse seen here is sampled
    chk("mux sel", o_mux_sel, 32'h5);
    wait_start(50);
    chk("start delay", n, 32'h5);
    chk("mux seen", mux_chan, 32'h5);
    for (int k = 1; k < 15; k++) sw(k[3:0]);
    rd(8'h40, rv);
    chk("no wrap at 15", rv[2], 32'h0);
    sw(4'hf);
    cyc(2);
    rd(8'h40, rv);
    chk("wrap at 16", rv[2], 32'h1);
    wr(8'h48, 32'h4);
    cyc(2);
    chk("irq on", o_irq, 32'h1);
    wr(8'h44, 32'h4);
    cyc(2);
    chk("irq off", o_irq, 32'h0);
  endtask : t_seq

  // Plain reset sync, then the gated start
  task automatic t_sync();
    wr(8'h18, 32'h0000_0800);
    i_gated_sync_select <= 1'b1;
    i_sync_pin_n <= 1'b0;
    cyc(8);
    chk("sync reset", o_conv_reset, 32'h1);
    i_multi_chan <= 1'b1;
    cyc(3);
    chk("gated no reset", o_conv_reset, 32'h0);
    sw(4'h2);
    cyc(12);
    chk("withheld", {o_conv_withheld, o_conv_start}, 32'h2);
    i_sync_pin_n <= 1'b1;
    n = 0;
    wait_start(40);
    chk("released start", o_conv_start, 32'h1);
    chk("hold left", o_conv_withheld, 32'h0);
    rd(8'h40, rv);
    chk("hold events", rv[1:0], 32'h3);
    wr(8'h44, 32'hf);
  endtask : t_sync

  // Error pin as input, open-drain output and off
  task automatic t_err();
    wr(8'h18, 32'h0000_0200);
    pull_low <= 1'b1;
    cyc(6);
    chk("ext err", o_ext_err, 32'h1);
    rd(8'h18, rv);
    chk("pin read low", rv, 32'h0000_0200);
    pull_low <= 1'b0;
    cyc(6);
    rd(8'h18, rv);
    chk("pin read high", rv, 32'h0000_0300);
    wr(8'h18, 32'h0000_0400);
    i_status_err <= 1'b1;
    cyc(3);
    chk("drain low", fault_wire, 32'h0);
    i_status_err <= 1'b0;
    cyc(3);
    chk("drain released", fault_wire, 32'h1);
    wr(8'h18, 32'h0);
    cyc(2);
    chk("pin off", o_fault_pin_oe, 32'h0);
  endtask : t_err

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    t_reset();
    t_cfg();
    t_seq();
    t_sync();
    t_err();
    print_verdict();
  end

  // Watchdog, far beyond the roughly 150 cycles needed
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
endmodule : gpio_sync_error_pin_control_tb_top
